// ### verilog/xisa_exec.sv
// execution of extended instructions and indexed operand addressing
// assumes one instruction word per enabled cycle and a data port with
// combinational read data for the address presented in the same cycle
//
// How it works
// - push literal stores k at stack pointer, then pointer decrements, one cycle.
// - pointer subtract removes six-bit k from pointer 0, 1 or 2, flags untouched.
// - subtract-and-return lowers stack pointer, loads pc from stack top, second cycle idle.
// - pointer-subtract with select 3 is subtract-and-return on stack pointer only.
// - extension enable also turns on indexed offset addressing.
// - extension off: operand is access bank or selected bank address.
// - extension on, access 0, operand up to 5Fh adds to stack pointer.
// - operands above 5Fh keep the normal access bank meaning.
// - remap covers all byte and bit instructions; destination bit unchanged.
// - stack pointer zero gives the original access mapping.
// - indexed add-w-to-file adds w to indexed byte, sets five flags.
// - configuration bit enables extension; low means disabled.
// - indexed move reads 00h from indirect source, skips indirect destination.
`timescale 1ns/100ps
module xisa_exec (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_ext_cfg,
    input wire logic i_insn_valid,
    input wire logic [15:0] i_insn,
    input wire logic [3:0] i_bank_select,
    input wire logic [7:0] i_w,
    input wire logic [7:0] i_rd_data,
    input wire logic [11:0] i_return_stack_top,
    output logic [11:0] o_rd_addr,
    output logic o_wr_en,
    output logic [11:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic o_w_load,
    output logic [7:0] o_w_data,
    output logic o_flags_load,
    output logic [4:0] o_flags,
    output logic o_pc_load,
    output logic [11:0] o_pc,
    output logic o_busy,
    output logic [11:0] o_ptr0,
    output logic [11:0] o_ptr1,
    output logic [11:0] o_stack_pointer_register
);
    import xisa_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    exec_state_t state_r, state_nxt;
    logic [11:0] ptr_r [3];
    logic [11:0] ptr_nxt [3];
    logic ext_r, ext_nxt;
    logic cfg_taken_r, cfg_taken_nxt;
    logic [11:0] rd_addr_r, rd_addr_nxt;
    logic wr_en_r, wr_en_nxt;
    logic [11:0] wr_addr_r, wr_addr_nxt;
    logic [7:0] wr_data_r, wr_data_nxt;
    logic w_load_r, w_load_nxt;
    logic [7:0] w_data_r, w_data_nxt;
    logic fl_load_r, fl_load_nxt;
    logic [4:0] flags_r, flags_nxt;
    logic pc_load_r, pc_load_nxt;
    logic [11:0] pc_r, pc_nxt;
    logic [7:0] move_data_r, move_data_nxt;
    logic [6:0] move_dst_r, move_dst_nxt;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers
    logic [7:0] opc;
    logic [1:0] fsel;
    logic [5:0] k6;
    logic [11:0] eff_addr;
    logic [7:0] add_sum;
    logic [4:0] add_flags;
    logic is_add_w_to_file_op;
    logic [11:0] move_addr;

    assign opc = i_insn[15:8];
    assign fsel = i_insn[7:6];
    assign k6 = i_insn[5:0];
    assign is_add_w_to_file_op = (i_insn[15:12] == OPC_ADD_W_TO_FILE_OP) && (i_insn[11:10] == OPC_ADD_W_TO_FILE_OP_SUB);
    // the indexed move offsets are 7 bits and always relative
    assign move_addr = ptr_r[SEL_SP] + {5'h00, i_insn[6:0]};

    xisa_addr_map u_addr_map (
        .i_ext_en(ext_r),
        .i_access(i_insn[8]),
        .i_operand(i_insn[7:0]),
        .i_bank_select(i_bank_select),
        .i_stack_ptr(ptr_r[SEL_SP]),
        .o_addr(eff_addr)
    );

    xisa_adder u_adder (
        .i_a(i_w),
        .i_b(i_rd_data),
        .o_sum(add_sum),
        .o_flags(add_flags)
    );

    function automatic logic is_indirect(input logic [11:0] a);
        is_indirect = (a >= INDF_LO) && (a <= INDF_HI) && (a[2:0] == 3'h7 || a[2:0] == 3'h3
            || a[2:0] == 3'h4 || a[2:0] == 3'h5 || a[2:0] == 3'h6);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        state_nxt = state_r;
        ptr_nxt = ptr_r;
        ext_nxt = ext_r;
        cfg_taken_nxt = 1'b1;
        rd_addr_nxt = rd_addr_r;
        wr_en_nxt = 1'b0;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        w_load_nxt = 1'b0;
        w_data_nxt = w_data_r;
        fl_load_nxt = 1'b0;
        flags_nxt = flags_r;
        pc_load_nxt = 1'b0;
        pc_nxt = pc_r;
        move_data_nxt = move_data_r;
        move_dst_nxt = move_dst_r;
        // the configuration bit is nonvolatile: caught once after reset
        if (!cfg_taken_r) begin
            ext_nxt = i_ext_cfg;
        end
        case (state_r)
            ST_EXEC: begin
                rd_addr_nxt = eff_addr;
                if (i_insn_valid && cfg_taken_r) begin
                    if (ext_r && opc == OPC_PUSH_LIT) begin
                        wr_en_nxt = 1'b1;
                        wr_addr_nxt = ptr_r[SEL_SP];
                        wr_data_nxt = i_insn[7:0];
                        ptr_nxt[SEL_SP] = ptr_r[SEL_SP] - 12'h001;
                    end else if (ext_r && opc == OPC_PTR_SUB) begin
                        if (fsel == SEL_STACK) begin
                            ptr_nxt[SEL_SP] = ptr_r[SEL_SP] - {6'h00, k6};
                            pc_load_nxt = 1'b1;
                            pc_nxt = i_return_stack_top;
                            state_nxt = ST_RET_NOP;
                        end else begin
                            ptr_nxt[fsel] = ptr_r[fsel] - {6'h00, k6};
                        end
                    end else if (ext_r && opc == OPC_PTR_ADD) begin
                        if (fsel == SEL_STACK) begin
                            ptr_nxt[SEL_SP] = ptr_r[SEL_SP] + {6'h00, k6};
                            pc_load_nxt = 1'b1;
                            pc_nxt = i_return_stack_top;
                            state_nxt = ST_RET_NOP;
                        end else begin
                            ptr_nxt[fsel] = ptr_r[fsel] + {6'h00, k6};
                        end
                    end else if (ext_r && opc == OPC_IDX_MOVE && i_insn[7]) begin
                        rd_addr_nxt = move_addr;
                        state_nxt = ST_MOVE_SRC;
                    end else if (is_add_w_to_file_op) begin
                        // rd data answers the address driven this cycle
                        fl_load_nxt = 1'b1;
                        flags_nxt = add_flags;
                        if (i_insn[9]) begin
                            wr_en_nxt = 1'b1;
                            wr_addr_nxt = eff_addr;
                            wr_data_nxt = add_sum;
                        end else begin
                            w_load_nxt = 1'b1;
                            w_data_nxt = add_sum;
                        end
                    end
                end
            end
            ST_RET_NOP: begin
                state_nxt = ST_EXEC;
            end
            ST_MOVE_SRC: begin
                // source read is presented now; capture it with the second word
                move_data_nxt = is_indirect(rd_addr_r) ? 8'h00 : i_rd_data;
                if (i_insn_valid) begin
                    move_dst_nxt = i_insn[6:0];
                    state_nxt = ST_MOVE_DST;
                end
            end
            ST_MOVE_DST: begin
                wr_addr_nxt = ptr_r[SEL_SP] + {5'h00, move_dst_r};
                wr_data_nxt = move_data_r;
                wr_en_nxt = !is_indirect(ptr_r[SEL_SP] + {5'h00, move_dst_r});
                state_nxt = ST_EXEC;
            end
            default: begin
                state_nxt = ST_EXEC;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_EXEC;
            for (int i = 0; i < 3; i++) begin
                ptr_r[i] <= SP_RESET;
            end
            ext_r <= 1'b0;
            cfg_taken_r <= 1'b0;
            rd_addr_r <= 12'h000;
            wr_en_r <= 1'b0;
            wr_addr_r <= 12'h000;
            wr_data_r <= 8'h00;
            w_load_r <= 1'b0;
            w_data_r <= 8'h00;
            fl_load_r <= 1'b0;
            flags_r <= 5'h00;
            pc_load_r <= 1'b0;
            pc_r <= PC_RESET;
            move_data_r <= 8'h00;
            move_dst_r <= 7'h00;
        end else if (i_ce) begin
            state_r <= state_nxt;
            ptr_r <= ptr_nxt;
            ext_r <= ext_nxt;
            cfg_taken_r <= cfg_taken_nxt;
            rd_addr_r <= rd_addr_nxt;
            wr_en_r <= wr_en_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
            w_load_r <= w_load_nxt;
            w_data_r <= w_data_nxt;
            fl_load_r <= fl_load_nxt;
            flags_r <= flags_nxt;
            pc_load_r <= pc_load_nxt;
            pc_r <= pc_nxt;
            move_data_r <= move_data_nxt;
            move_dst_r <= move_dst_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign o_rd_addr = rd_addr_r;
    assign o_wr_en = wr_en_r;
    assign o_wr_addr = wr_addr_r;
    assign o_wr_data = wr_data_r;
    assign o_w_load = w_load_r;
    assign o_w_data = w_data_r;
    assign o_flags_load = fl_load_r;
    assign o_flags = flags_r;
    assign o_pc_load = pc_load_r;
    assign o_pc = pc_r;
    assign o_busy = (state_r != ST_EXEC);
    assign o_ptr0 = ptr_r[0];
    assign o_ptr1 = ptr_r[1];
    assign o_stack_pointer_register = ptr_r[SEL_SP];
endmodule // xisa_exec

// ### verilog/xisa_pkg.sv
// constants for the extended-instruction execution block
// assumes a 16-bit instruction word and a 12-bit data address space
package xisa_pkg;
    localparam int DATA_AW = 12;
    localparam int INSN_W = 16;
    // opcode high bytes
    localparam logic [7:0] OPC_PTR_ADD = 8'hE8;
    localparam logic [7:0] OPC_PTR_SUB = 8'hE9;
    localparam logic [7:0] OPC_PUSH_LIT = 8'hFA;
    localparam logic [7:0] OPC_IDX_MOVE = 8'hEB;
    localparam logic [1:0] SEL_STACK = 2'h3;
    localparam logic [1:0] SEL_SP = 2'h2;
    localparam logic [7:0] OFFSET_LIMIT = 8'h5F;
    localparam logic [11:0] SP_RESET = 12'h000;
    localparam logic [11:0] PC_RESET = 12'h000;
    // indirect data registers whose access the indexed move refuses
    localparam logic [11:0] INDF_LO = 12'hFDB;
    localparam logic [11:0] INDF_HI = 12'hFEF;
    localparam logic [3:0] OPC_ADD_W_TO_FILE_OP = 4'h2;
    localparam logic [1:0] OPC_ADD_W_TO_FILE_OP_SUB = 2'h1;
    // status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    localparam int FLAG_W = 5;
    typedef enum logic [1:0] {ST_EXEC, ST_RET_NOP, ST_MOVE_SRC, ST_MOVE_DST} exec_state_t;
endpackage

// ### verilog/xisa_addr_map.sv
// effective data address for byte/bit instruction operands
// assumes the core supplies the operand, access bit and bank select
`timescale 1ns/100ps
module xisa_addr_map (
    input wire logic i_ext_en,
    input wire logic i_access,
    input wire logic [7:0] i_operand,
    input wire logic [3:0] i_bank_select,
    input wire logic [11:0] i_stack_ptr,
    output logic [11:0] o_addr
);
    import xisa_pkg::*;
    logic [11:0] sum;
    always_comb begin
        sum = i_stack_ptr + {4'h0, i_operand};
        if (i_access) begin
            o_addr = {i_bank_select, i_operand};
        end else if (i_ext_en && (i_operand <= OFFSET_LIMIT)) begin
            o_addr = sum;
        end else if (i_operand <= OFFSET_LIMIT) begin
            o_addr = {4'h0, i_operand};
        end else begin
            o_addr = {4'hF, i_operand};
        end
    end
endmodule // xisa_addr_map

// ### verilog/xisa_adder.sv
// 8-bit add with the five arithmetic status flags
// assumes operands are already fetched
`timescale 1ns/100ps
module xisa_adder (
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    output logic [7:0] o_sum,
    output logic [4:0] o_flags
);
    import xisa_pkg::*;
    logic [8:0] full;
    logic [4:0] low;
    always_comb begin
        full = {1'b0, i_a} + {1'b0, i_b};
        low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
        o_sum = full[7:0];
        o_flags = 5'h00;
        o_flags[FLAG_C] = full[8];
        o_flags[FLAG_DC] = low[4];
        o_flags[FLAG_Z] = (full[7:0] == 8'h00);
        o_flags[FLAG_OV] = (i_a[7] == i_b[7]) && (full[7] != i_a[7]);
        o_flags[FLAG_N] = full[7];
    end
endmodule // xisa_adder

// ### test/xisa_exec_monitor.sv
// port assertions for the extended-instruction execution block
// assumes i_ext_cfg is steady around each release of reset
`timescale 1ns/100ps
module xisa_exec_monitor import xisa_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_ext_cfg,
    input wire logic i_insn_valid,
    input wire logic [15:0] i_insn,
    input wire logic [3:0] i_bank_select,
    input wire logic [7:0] i_w,
    input wire logic [7:0] i_rd_data,
    input wire logic [11:0] i_return_stack_top,
    input wire logic [11:0] o_rd_addr,
    input wire logic o_wr_en,
    input wire logic [11:0] o_wr_addr,
    input wire logic [7:0] o_wr_data,
    input wire logic o_w_load,
    input wire logic [7:0] o_w_data,
    input wire logic o_flags_load,
    input wire logic o_pc_load,
    input wire logic [11:0] o_pc,
    input wire logic o_busy,
    input wire logic [11:0] o_ptr0,
    input wire logic [11:0] o_stack_pointer_register
);
    logic seen_r;
    logic ext_r;
    logic take;
    logic add_w_to_file_op;
    logic [7:0] k;
    logic [7:0] sum;
    logic [11:0] sp;
    assign take = i_ce && i_insn_valid && !o_busy && seen_r;
    assign add_w_to_file_op = i_insn[15:12] == OPC_ADD_W_TO_FILE_OP && i_insn[11:10] == OPC_ADD_W_TO_FILE_OP_SUB;
    assign k = i_insn[7:0];
    assign sum = i_w + i_rd_data;
    assign sp = o_stack_pointer_register;
    // config is trusted only as latched on the first enabled edge, like the block
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seen_r <= 1'b0;
            ext_r <= 1'b0;
        end else if (i_ce && !seen_r) begin
            seen_r <= 1'b1;
            ext_r <= i_ext_cfg;
        end
    end
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    AST_PUSH: assert property (take && ext_r && i_insn[15:8] == OPC_PUSH_LIT |=> o_wr_en
        && o_wr_addr == $past(sp) && o_wr_data == $past(k) && sp == $past(sp) - 12'h001)
        else $error("push literal store or decrement wrong");
    AST_SUB_PTR: assert property (take && ext_r && i_insn[15:6] == {OPC_PTR_SUB, 2'h0} |=>
        o_ptr0 == $past(o_ptr0) - {6'h00, $past(i_insn[5:0])} && !o_flags_load)
        else $error("pointer subtract wrong");
    AST_SUB_RET: assert property (take && ext_r && i_insn[15:6] == {OPC_PTR_SUB, SEL_STACK} |=>
        o_pc_load && o_pc == $past(i_return_stack_top) && o_busy && $stable(o_ptr0)
        && sp == $past(sp) - {6'h00, $past(i_insn[5:0])} ##1 !o_busy && !o_pc_load)
        else $error("subtract and return wrong");
    AST_EXT_OFF: assert property (take && !ext_r && i_insn[15:12] == 4'hE |=>
        !o_wr_en && !o_pc_load && !o_busy && $stable(sp) && $stable(o_ptr0))
        else $error("extended opcode acted while disabled");
    AST_MAP_INDEXED: assert property (take && ext_r && add_w_to_file_op && !i_insn[8] && k <= OFFSET_LIMIT
        |=> o_rd_addr == $past(sp) + {4'h0, $past(k)})
        else $error("indexed operand address wrong");
    AST_MAP_LITERAL: assert property (take && add_w_to_file_op && !i_insn[8] && (!ext_r || k > OFFSET_LIMIT)
        |=> o_rd_addr == {(($past(k) > OFFSET_LIMIT) ? 4'hF : 4'h0), $past(k)})
        else $error("access bank operand address wrong");
    AST_MAP_BANK: assert property (take && add_w_to_file_op && i_insn[8] |=>
        o_rd_addr == {$past(i_bank_select), $past(k)})
        else $error("banked operand address wrong");
    AST_ADD: assert property (take && add_w_to_file_op |=> o_flags_load && ($past(i_insn[9]) ?
        (o_wr_en && o_wr_data == $past(sum)) : (o_w_load && o_w_data == $past(sum))))
        else $error("add w to file result wrong");
    COV_PUSH: cover property (take && ext_r && i_insn[15:8] == OPC_PUSH_LIT);
    COV_RET: cover property (o_pc_load ##1 !o_busy);
    COV_MOVE: cover property (take && ext_r && i_insn[15:8] == OPC_IDX_MOVE ##1 o_busy ##1 o_wr_en);
endmodule // xisa_exec_monitor
bind xisa_exec xisa_exec_monitor u_xisa_exec_monitor (.*);

// ### test/testbench.sv
// self-checking bench for the extended-instruction execution block
// assumes outputs answer on the edge that takes a word, checked half a cycle later
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
module testbench;
    import xisa_pkg::*;
    logic i_core_clk, i_rst_n, i_ce, i_ext_cfg, i_insn_valid;
    logic [15:0] i_insn;
    logic [3:0] i_bank_select;
    logic [7:0] i_w, i_rd_data, o_wr_data, o_w_data;
    logic [11:0] i_return_stack_top, o_rd_addr, o_wr_addr, o_pc, o_ptr0, o_ptr1;
    logic [11:0] o_stack_pointer_register;
    logic o_wr_en, o_w_load, o_flags_load, o_pc_load, o_busy;
    logic [4:0] o_flags;
    int err_count, comparisons;
    xisa_exec u_xisa_exec (.*);
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic do_reset(input logic cfg);
        i_rst_n = 1'b0;
        i_ext_cfg = cfg;
        repeat (4) @(negedge i_core_clk);
        i_rst_n = 1'b1;
    endtask
    // one spare cycle between words keeps valid from being driven twice in a step
    task automatic issue(input logic [15:0] insn, input logic [7:0] rd);
        @(negedge i_core_clk);
        i_insn_valid = 1'b1;
        i_insn = insn;
        i_rd_data = rd;
        @(negedge i_core_clk);
        i_insn_valid = 1'b0;
    endtask
    task automatic move(input logic [6:0] src, input logic [6:0] dst, input logic [7:0] rd);
        @(negedge i_core_clk);
        i_insn_valid = 1'b1;
        i_insn = {OPC_IDX_MOVE, 1'b1, src};
        @(negedge i_core_clk);
        `CHK(o_busy, 1'b1)
        i_insn = {8'hF0, 1'b0, dst};
        i_rd_data = rd;
        @(negedge i_core_clk);
        i_insn_valid = 1'b0;
        // the destination write leaves the flops one edge after the second word
        @(negedge i_core_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_off();
        do_reset(1'b0);
        `CHK({o_stack_pointer_register, o_ptr0, o_busy}, 25'h0)
        issue(16'hFA08, 8'h00);
        `CHK(o_wr_en, 1'b0)
        issue(16'hE8BF, 8'h00);
        `CHK(o_stack_pointer_register, 12'h000)
        i_w = 8'h03;
        issue(16'h2410, 8'h05);
        `CHK({o_rd_addr, o_w_data}, 20'h01008)
        issue(16'h2534, 8'h00);
        `CHK(o_rd_addr, {i_bank_select, 8'h34})
        $display("test extension off done");
    endtask
    task automatic test_push();
        do_reset(1'b1);
        issue(16'h2410, 8'h05);
        `CHK(o_rd_addr, 12'h010)
        issue(16'hE8BF, 8'h00);
        issue(16'hFA08, 8'h00);
        `CHK({o_wr_en, o_wr_addr, o_wr_data}, 21'h103F08)
        issue(16'hFAFF, 8'h00);
        `CHK({o_wr_en, o_wr_addr, o_wr_data}, 21'h103EFF)
        `CHK(o_stack_pointer_register, 12'h03D)
        $display("test push literal done");
    endtask
    task automatic test_ptr_sub();
        issue(16'hE92A, 8'h00);
        `CHK({o_ptr0, o_flags_load}, 13'h1FAC)
        issue(16'hE96A, 8'h00);
        `CHK(o_ptr1, 12'hFD6)
        issue(16'hE9AA, 8'h00);
        `CHK({o_stack_pointer_register, o_ptr0}, 24'h013FD6)
        $display("test pointer subtract done");
    endtask
    task automatic test_return();
        i_return_stack_top = 12'hABC;
        @(negedge i_core_clk);
        i_insn_valid = 1'b1;
        i_insn = 16'hE9C3;
        @(negedge i_core_clk);
        i_insn = 16'hFA55;
        `CHK({o_pc_load, o_pc, o_busy}, 14'h3579)
        `CHK({o_stack_pointer_register, o_ptr1}, 24'h010FD6)
        @(negedge i_core_clk);
        i_insn_valid = 1'b0;
        `CHK({o_busy, o_wr_en, o_pc_load}, 3'h0)
        $display("test subtract and return done");
    endtask
    task automatic test_indexed();
        i_w = 8'h7F;
        issue(16'h242C, 8'h01);
        `CHK({o_rd_addr, o_w_load, o_w_data, o_flags}, 26'h00F301A)
        i_w = 8'h80;
        issue(16'h265F, 8'h80);
        `CHK({o_rd_addr, o_wr_en, o_wr_data, o_w_load}, 22'h1BE00)
        `CHK({o_wr_addr, o_flags}, 17'h00DED)
        i_w = 8'h17;
        issue(16'h2460, 8'hF0);
        `CHK({o_rd_addr, o_w_data, o_flags}, 25'h1EC00E1)
        issue(16'h8E05, 8'h00);
        `CHK(o_rd_addr, 12'h015)
        $display("test indexed operands done");
    endtask
    task automatic test_moves();
        move(7'h05, 7'h06, 8'h33);
        `CHK({o_wr_en, o_wr_addr, o_wr_data}, 21'h101633)
        issue(16'hE9AB, 8'h00);
        move(7'h00, 7'h10, 8'hAA);
        `CHK({o_wr_en, o_wr_addr, o_wr_data}, 21'h1FF500)
        move(7'h10, 7'h00, 8'h44);
        `CHK(o_wr_en, 1'b0)
        issue(16'h242C, 8'h00);
        `CHK(o_rd_addr, 12'h011)
        $display("test indexed move done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst_n = 1'b0;
        i_ce = 1'b1;
        i_ext_cfg = 1'b0;
        i_insn_valid = 1'b0;
        i_insn = 16'h0000;
        i_bank_select = 4'h3;
        i_w = 8'h00;
        i_rd_data = 8'h00;
        i_return_stack_top = 12'h000;
        err_count = 0;
        comparisons = 0;
        test_off();
        test_push();
        test_ptr_sub();
        test_return();
        test_indexed();
        test_moves();
        give_verdict();
    end
    // the tests need about 57 cycles; over forty times that means a hang
    initial begin
        repeat (2500) @(posedge i_core_clk);
        err_count++;
        give_verdict();
    end
endmodule // testbench
